// *** bench/asp_drive_model.sv ***
`timescale 1ns/1ps
module asp_drive_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        pulse_out,
   input  wire logic        drop,
   output logic             drive_ready,
   output logic [31:0]      count
);
   logic prev_ff;
   // drive signals not ready while the bench injects a fault
   assign drive_ready = !drop;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_ff <= 1'b0;
         count <= 32'h0;
      end else begin
         prev_ff <= pulse_out;
         if (pulse_out && !prev_ff)
            count <= count + 32'h1;
      end
   end
endmodule

// *** bench/asp_stop_monitor.sv ***
`timescale 1ns/1ps
module asp_stop_monitor (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic        pulse_out,
   input wire logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence rd_wait;
      !arready ##1 rvalid;
   endsequence
   sequence wr_wait;
      !awready && !wready ##1 bvalid;
   endsequence
   b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("bvalid or bresp changed before bready");
   b_done_a: assert property (bvalid && bready |=>
                              awready && wready && !bvalid)
      else $error("write channel not reopened after response");
   r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("rvalid or rdata changed before rready");
   r_lat_a: assert property (arvalid && arready |=> rd_wait)
      else $error("read answer not two edges after address");
   w_lat_a: assert property (awvalid && awready && wvalid && wready |=>
                             wr_wait)
      else $error("write answer not two edges after handshake");
   r_busy_a: assert property (rvalid |-> !arready)
      else $error("read address accepted while answer pending");
   w_busy_a: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while response pending");
   rst_quiet_a: assert property ($fell(rst) |-> !pulse_out && !irq)
      else $error("outputs active right after reset");
endmodule
bind asp_stop_ctrl asp_stop_monitor asp_stop_monitor_i (
   .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .pulse_out(pulse_out), .irq(irq));

// *** bench/axis_stop_processing_tb.sv ***
`timescale 1ns/1ps
`include "asp_defs.svh"
`define CHK(n,e,a) begin check_count++; if ((a) !== (e)) begin failures++; \
 $display("BAD %s exp %h got %h", n, e, a); end end
module axis_stop_processing_tb;
   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, drop;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d, p0, pcount;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   logic        awready, wready, bvalid, arready, rvalid, drive_ready;
   logic        pulse_out, dir_out, irq;
   int          failures, check_count;
   logic [7:0]  st_bit [4] = '{8'h02, 8'h04, 8'h08, 8'h80};
   logic [7:0]  exp_op [4] = '{`ASP_OP_STOPPED, `ASP_OP_ERROR,
                                `ASP_OP_ERROR, `ASP_OP_STANDBY};
   asp_stop_ctrl #(.MS_CYC(20)) asp_stop_ctrl_i (.clk(clk), .rst(rst),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .drive_ready(drive_ready), .pulse_out(pulse_out),
      .dir_out(dir_out), .irq(irq));
   asp_drive_model asp_drive_model_i (.clk(clk), .rst(rst),
      .pulse_out(pulse_out), .drop(drop), .drive_ready(drive_ready),
      .count(pcount));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task end_sim;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      rsp = bresp;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      v = rdata;
      rsp = rresp;
   endtask
   task wait_idle;
      do rd(`ASP_REG_STATUS, d);
      while (d[13:8] !== 6'h01);
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      failures++;
      end_sim();
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, drop} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(`ASP_REG_STATUS, d);
      `CHK("status_reset", 32'h00010100, d)
      rd(8'h34, d);
      `CHK("unmapped_resp", `ASP_RESP_SLVERR, rsp)
      wr(8'h34, 32'h0);
      `CHK("unmapped_wr", `ASP_RESP_SLVERR, rsp)
      wr(`ASP_REG_SPEED, 32'hffffff);
      wr(`ASP_REG_BIAS, 32'h400000);
      wr(`ASP_REG_ACC, 32'h100000);
      for (int a = `ASP_REG_TPOS; a <= `ASP_REG_TSPD; a += 4)
         wr(8'(a), 32'h5);
      rd(`ASP_REG_SPEED, d);
      `CHK("speed", 32'hffffff, d)
      wr(`ASP_REG_TARGET, 32'h3);
      wr(`ASP_REG_CTRL, 32'h2);
      wait_idle();
      `CHK("op_done", `ASP_OP_STANDBY, d[7:0])
      `CHK("pulses_hit", 32'h3, pcount)
      `CHK("irq_masked", 1'b0, irq)
      wr(`ASP_REG_IMASK, 32'h7);
      @(posedge clk);
      `CHK("irq_on", 1'b1, irq)
      rd(`ASP_REG_ISTAT, d);
      `CHK("istat_hit", 1'b1, d[2])
      @(posedge clk);
      `CHK("irq_clear", 1'b0, irq)
      for (int k = 0; k < 4; k++) begin
         wr(`ASP_REG_TARGET, 32'hffffffff);
         p0 = pcount;
         wr(`ASP_REG_CTRL, {23'h0, k == 3, st_bit[k]});
         repeat (400) @(posedge clk);
         `CHK("dir", k == 3, dir_out)
         if (k == 3) wr(`ASP_REG_CTRL, 32'h10);
         case (k)
            0: wr(`ASP_REG_CTRL, 32'h20);
            1: drop <= 1'b1;
            2: wr(`ASP_REG_CTRL, 32'h40);
            default: wr(`ASP_REG_TARGET, 32'h1);
         endcase
         if (k == 0) begin
            wr(`ASP_REG_CTRL, 32'h20);
            rd(`ASP_REG_STATUS, d);
            `CHK("ramp_kept", 1'b0, d[8])
         end
         wait_idle();
         `CHK("op_after_stop", exp_op[k], d[7:0])
         drop <= 1'b0;
         rd(`ASP_REG_POS, d);
         `CHK("pulses_whole", pcount - p0, d)
         rd(`ASP_REG_ISTAT, d);
         `CHK("istat_err", k == 1 || k == 2, d[1])
      end
      p0 = pcount;
      wr(`ASP_REG_CTRL, 32'h20);
      repeat (50) @(posedge clk);
      rd(`ASP_REG_STATUS, d);
      `CHK("idle_state", 6'h01, d[13:8])
      `CHK("idle_pulses", p0, pcount)
      end_sim();
   end
endmodule

// *** src/asp_axil.sv ***
`timescale 1ns/1ps
`include "asp_defs.svh"
module asp_axil (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic [7:0]      awaddr,
   input  wire logic            awvalid,
   output logic                 awready,
   input  wire logic [31:0]     wdata,
   input  wire logic [3:0]      wstrb,
   input  wire logic            wvalid,
   output logic                 wready,
   output logic [1:0]           bresp,
   output logic                 bvalid,
   input  wire logic            bready,
   input  wire logic [7:0]      araddr,
   input  wire logic            arvalid,
   output logic                 arready,
   output logic [31:0]          rdata,
   output logic [1:0]           rresp,
   output logic                 rvalid,
   input  wire logic            rready,
   output asp_pkg::asp_wr_t     wr,
   output asp_pkg::asp_rd_t     rd,
   input  wire logic [31:0]     rd_data
);
   typedef struct packed {
      logic             awready;
      logic             wready;
      logic             aw_ok;
      logic             w_ok;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [31:0]      rdata;
      asp_pkg::asp_wr_t wr;
      asp_pkg::asp_rd_t rd;
   } asp_axil_t;

   asp_axil_t s_ff;
   asp_axil_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.wr.en = 1'b0;
      nxt_s.rd.en = 1'b0;
      if (awvalid && s_ff.awready) begin
         nxt_s.awready = 1'b0;
         nxt_s.aw_ok = 1'b1;
         nxt_s.wr.addr = awaddr;
      end
      if (wvalid && s_ff.wready) begin
         nxt_s.wready = 1'b0;
         nxt_s.w_ok = 1'b1;
         nxt_s.wr.data = wdata;
         nxt_s.wr.strb = wstrb;
      end
      if (s_ff.aw_ok && s_ff.w_ok) begin
         nxt_s.aw_ok = 1'b0;
         nxt_s.w_ok = 1'b0;
         nxt_s.wr.en = 1'b1;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = asp_pkg::asp_addr_ok(s_ff.wr.addr) ?
                       `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
      end
      if (s_ff.bvalid && bready) begin
         nxt_s.bvalid = 1'b0;
         nxt_s.awready = 1'b1;
         nxt_s.wready = 1'b1;
      end
      if (arvalid && s_ff.arready) begin
         nxt_s.arready = 1'b0;
         nxt_s.rd.en = 1'b1;
         nxt_s.rd.addr = araddr;
      end
      if (s_ff.rd.en) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rdata = rd_data;
         nxt_s.rresp = asp_pkg::asp_addr_ok(s_ff.rd.addr) ?
                       `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
      end
      if (s_ff.rvalid && rready) begin
         nxt_s.rvalid = 1'b0;
         nxt_s.arready = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
         s_ff.awready <= 1'b1;
         s_ff.wready <= 1'b1;
         s_ff.arready <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign awready = s_ff.awready;
   assign wready  = s_ff.wready;
   assign bvalid  = s_ff.bvalid;
   assign bresp   = s_ff.bresp;
   assign arready = s_ff.arready;
   assign rvalid  = s_ff.rvalid;
   assign rdata   = s_ff.rdata;
   assign rresp   = s_ff.rresp;
   assign wr      = s_ff.wr;
   assign rd      = s_ff.rd;
endmodule

// *** src/asp_defs.svh ***
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

`define ASP_CLK_NS      20
`define ASP_MS_NS       1000000
`define ASP_MS_CYC      (`ASP_MS_NS / `ASP_CLK_NS)
`define ASP_SPD_W       24
`define ASP_TIM_W       16

`define ASP_REG_CTRL    8'h00
`define ASP_REG_SPEED   8'h04
`define ASP_REG_BIAS    8'h08
`define ASP_REG_ACC     8'h0c
`define ASP_REG_TARGET  8'h10
`define ASP_REG_TPOS    8'h14
`define ASP_REG_TJOG    8'h18
`define ASP_REG_THOME   8'h1c
`define ASP_REG_TSPD    8'h20
`define ASP_REG_STATUS  8'h24
`define ASP_REG_POS     8'h28
`define ASP_REG_ISTAT   8'h2c
`define ASP_REG_IMASK   8'h30

`define ASP_CMD_TABLE   0
`define ASP_CMD_DIRECT  1
`define ASP_CMD_JOG     2
`define ASP_CMD_HOME    3
`define ASP_CMD_SPDCHG  4
`define ASP_CMD_HALT    5
`define ASP_CMD_PROG    6
`define ASP_CMD_DUAL    7
`define ASP_CMD_DIR     8

`define ASP_OP_STANDBY  8'h00
`define ASP_OP_STOPPED  8'h01
`define ASP_OP_BUSY     8'h02
`define ASP_OP_ERROR    8'hff

`define ASP_IRQ_DONE    0
`define ASP_IRQ_ERR     1
`define ASP_IRQ_HIT     2

`define ASP_RESP_OKAY   2'h0
`define ASP_RESP_SLVERR 2'h2

`endif

// *** src/asp_div.sv ***
`timescale 1ns/1ps
`include "asp_defs.svh"
module asp_div #(
   parameter int NW = `ASP_SPD_W,
   parameter int DW = `ASP_TIM_W
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          go,
   input  wire logic [NW-1:0] num,
   input  wire logic [DW-1:0] den,
   output logic               done,
   output logic [NW-1:0]      quo
);
   localparam int CW = $clog2(NW + 1);

   if (NW < 2 || DW < 2) begin : g_chk
      $error("asp_div: widths too small");
   end

   typedef struct packed {
      logic          busy;
      logic          done;
      logic [CW-1:0] cnt;
      logic [DW:0]   rem;
      logic [DW-1:0] den;
      logic [NW-1:0] quo;
   } asp_div_t;

   asp_div_t s_ff;
   asp_div_t nxt_s;
   logic [DW:0] trial;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      trial = {s_ff.rem[DW-1:0], s_ff.quo[NW-1]};
      if (go) begin
         nxt_s.busy = 1'b1;
         nxt_s.cnt = CW'(NW);
         nxt_s.rem = '0;
         nxt_s.den = den;
         nxt_s.quo = num;
      end else if (s_ff.busy) begin
         nxt_s.quo = {s_ff.quo[NW-2:0], 1'b0};
         if (trial >= {1'b0, s_ff.den}) begin
            nxt_s.rem = trial - {1'b0, s_ff.den};
            nxt_s.quo[0] = 1'b1;
         end else begin
            nxt_s.rem = trial;
         end
         nxt_s.cnt = s_ff.cnt - 1'b1;
         if (s_ff.cnt == CW'(1)) begin
            nxt_s.busy = 1'b0;
            nxt_s.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign done = s_ff.done;
   assign quo  = s_ff.quo;
endmodule

// *** src/asp_pkg.sv ***
package asp_pkg;
`include "asp_defs.svh"

   typedef enum logic [5:0] {
      ASP_IDLE   = 6'h01,
      ASP_ACCEL  = 6'h02,
      ASP_RUN    = 6'h04,
      ASP_CALC   = 6'h08,
      ASP_DECEL  = 6'h10,
      ASP_FINISH = 6'h20
   } asp_state_t;

   typedef enum logic [1:0] {
      ASP_CTL_POS  = 2'h0,
      ASP_CTL_JOG  = 2'h1,
      ASP_CTL_HOME = 2'h2
   } asp_ctl_t;

   typedef struct packed {
      logic        en;
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } asp_wr_t;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
   } asp_rd_t;

   function automatic logic asp_addr_ok(logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `ASP_REG_IMASK);
   endfunction

endpackage

// *** src/asp_stop_ctrl.sv ***
`timescale 1ns/1ps
`include "asp_defs.svh"
module asp_stop_ctrl #(
   parameter int MS_CYC = `ASP_MS_CYC,
   parameter int SPD_W  = `ASP_SPD_W,
   parameter int TIM_W  = `ASP_TIM_W
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        drive_ready,
   output logic             pulse_out,
   output logic             dir_out,
   output logic             irq
);
   localparam int MSW = $clog2(MS_CYC);

   if (MS_CYC < 2 || SPD_W > 31 || TIM_W > SPD_W || TIM_W < 2)
   begin : g_chk
      $error("asp_stop_ctrl: unsupported parameters");
   end

   typedef struct packed {
      asp_pkg::asp_state_t st;
      asp_pkg::asp_ctl_t   ctl;
      logic                spdchg;
      logic                posmode;
      logic                dir;
      logic                pulse;
      logic                irq;
      logic                drv1;
      logic                drv2;
      logic                c_err;
      logic                c_halt;
      logic                div_go;
      logic [MSW-1:0]      ms;
      logic [31:0]         phase;
      logic [31:0]         pos;
      logic [31:0]         target;
      logic [SPD_W-1:0]    speed;
      logic [SPD_W-1:0]    tgt;
      logic [SPD_W-1:0]    step;
      logic [SPD_W-1:0]    r_speed;
      logic [SPD_W-1:0]    r_bias;
      logic [SPD_W-1:0]    r_acc;
      logic [TIM_W-1:0]    tleft;
      logic [TIM_W-1:0]    r_tpos;
      logic [TIM_W-1:0]    r_tjog;
      logic [TIM_W-1:0]    r_thome;
      logic [TIM_W-1:0]    r_tspd;
      logic [7:0]          op;
      logic [2:0]          ist;
      logic [2:0]          imask;
   } asp_main_t;

   asp_main_t        s_ff;
   asp_main_t        nxt_s;
   asp_pkg::asp_wr_t wr;
   asp_pkg::asp_rd_t rd;
   logic [31:0]      rd_data;
   logic             div_done;
   logic [SPD_W-1:0] div_quo;
   function automatic logic [31:0] wmerge(logic [31:0] old,
                                          asp_pkg::asp_wr_t w);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (w.strb[i]) begin
            r[i*8 +: 8] = w.data[i*8 +: 8];
         end
      end
      return r;
   endfunction
   function automatic logic hit_reg(asp_pkg::asp_wr_t w,
                                    logic [7:0] a);
      return w.en && (w.addr == a);
   endfunction
   // stop time of the running control
   function automatic logic [TIM_W-1:0] sel_time(asp_main_t q);
      if (q.spdchg) begin
         return q.r_tspd;
      end
      unique case (q.ctl)
         asp_pkg::ASP_CTL_JOG:  return q.r_tjog;
         asp_pkg::ASP_CTL_HOME: return q.r_thome;
         default:               return q.r_tpos;
      endcase
   endfunction
   logic [7:0]       cmd;
   logic             moving;
   logic             tick;
   logic [32:0]      acc;
   logic             wrap;
   logic [31:0]      pos_nx;
   logic             hit;
   logic             err;
   logic             ret;
   logic             cause;
   logic             start;
   logic [SPD_W-1:0] floor_spd;
   logic [SPD_W-1:0] dec_spd;
   logic [SPD_W-1:0] acc_spd;
   logic [TIM_W-1:0] t_sel;
   logic [SPD_W-1:0] div_num;
   logic [TIM_W-1:0] div_den;
   assign cmd = hit_reg(wr, `ASP_REG_CTRL) ? wr.data[7:0] : 8'h00;
   assign moving = (s_ff.st != asp_pkg::ASP_IDLE);
   assign tick = (s_ff.ms == '0);
   assign acc = {1'b0, s_ff.phase} + {{(33-SPD_W){1'b0}}, s_ff.speed};
   assign wrap = moving && acc[32];
   assign pos_nx = s_ff.pos + {31'h0, wrap};
   assign hit = s_ff.posmode && wrap && (pos_nx == s_ff.target);
   assign err = moving && (!s_ff.drv2 || cmd[`ASP_CMD_PROG]);
   assign ret = moving && s_ff.posmode &&
                hit_reg(wr, `ASP_REG_TARGET) && (wr.data <= s_ff.pos);
   assign cause = err || cmd[`ASP_CMD_HALT] || ret;
   assign start = |{cmd[`ASP_CMD_TABLE], cmd[`ASP_CMD_DIRECT],
                    cmd[`ASP_CMD_JOG], cmd[`ASP_CMD_HOME],
                    cmd[`ASP_CMD_DUAL]};
   assign floor_spd = (s_ff.r_bias == '0) ? SPD_W'(1) : s_ff.r_bias;
   assign dec_spd = ({1'b0, s_ff.speed} > {1'b0, floor_spd} + s_ff.step) ?
                    s_ff.speed - s_ff.step : floor_spd;
   assign acc_spd = ({1'b0, s_ff.speed} + s_ff.r_acc > {1'b0, s_ff.tgt}) ?
                    s_ff.tgt : s_ff.speed + s_ff.r_acc;
   assign t_sel = sel_time(s_ff);
   assign div_num = (s_ff.speed > floor_spd) ? s_ff.speed - floor_spd : '0;
   assign div_den = (s_ff.tleft == '0) ? TIM_W'(1) : s_ff.tleft;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.div_go = 1'b0;
      nxt_s.drv1 = drive_ready;
      nxt_s.drv2 = s_ff.drv1;
      nxt_s.ms = tick ? MSW'(MS_CYC - 1) : s_ff.ms - 1'b1;
      if (moving) begin
         nxt_s.phase = acc[31:0];
         nxt_s.pos = pos_nx;
      end
      if (wr.en) begin
         unique case (wr.addr)
            `ASP_REG_SPEED:  nxt_s.r_speed = SPD_W'(wmerge(
                                32'(s_ff.r_speed), wr));
            `ASP_REG_BIAS:   nxt_s.r_bias = SPD_W'(wmerge(
                                32'(s_ff.r_bias), wr));
            `ASP_REG_ACC:    nxt_s.r_acc = SPD_W'(wmerge(
                                32'(s_ff.r_acc), wr));
            `ASP_REG_TARGET: nxt_s.target = wmerge(s_ff.target, wr);
            `ASP_REG_TPOS:   nxt_s.r_tpos = TIM_W'(wmerge(
                                32'(s_ff.r_tpos), wr));
            `ASP_REG_TJOG:   nxt_s.r_tjog = TIM_W'(wmerge(
                                32'(s_ff.r_tjog), wr));
            `ASP_REG_THOME:  nxt_s.r_thome = TIM_W'(wmerge(
                                32'(s_ff.r_thome), wr));
            `ASP_REG_TSPD:   nxt_s.r_tspd = TIM_W'(wmerge(
                                32'(s_ff.r_tspd), wr));
            `ASP_REG_IMASK:  nxt_s.imask = 3'(wmerge(32'(s_ff.imask), wr));
            default: ;
         endcase
      end
      // error causes are recorded in every state except ASP_IDLE
      if (err) begin
         nxt_s.c_err = 1'b1;
      end
      unique case (s_ff.st)
         asp_pkg::ASP_IDLE: begin
            // stop causes do nothing here
            if (start && s_ff.drv2 && !cmd[`ASP_CMD_PROG]) begin
               nxt_s.st = asp_pkg::ASP_ACCEL;
               nxt_s.posmode = cmd[`ASP_CMD_TABLE] ||
                               cmd[`ASP_CMD_DIRECT] || cmd[`ASP_CMD_DUAL];
               nxt_s.ctl = cmd[`ASP_CMD_JOG]  ? asp_pkg::ASP_CTL_JOG :
                           cmd[`ASP_CMD_HOME] ? asp_pkg::ASP_CTL_HOME :
                                                asp_pkg::ASP_CTL_POS;
               nxt_s.spdchg = 1'b0;
               nxt_s.dir = wr.data[`ASP_CMD_DIR];
               nxt_s.speed = floor_spd;
               nxt_s.tgt = s_ff.r_speed;
               nxt_s.phase = '0;
               nxt_s.pos = '0;
               nxt_s.c_err = 1'b0;
               nxt_s.c_halt = 1'b0;
               nxt_s.op = `ASP_OP_BUSY;
               nxt_s.ms = MSW'(MS_CYC - 1);
            end
         end
         asp_pkg::ASP_ACCEL,
         asp_pkg::ASP_RUN: begin
            if (s_ff.st == asp_pkg::ASP_ACCEL && tick) begin
               nxt_s.speed = (s_ff.speed > s_ff.tgt) ? s_ff.tgt : acc_spd;
            end
            if (nxt_s.speed == s_ff.tgt) begin
               nxt_s.st = asp_pkg::ASP_RUN;
            end
            if (cmd[`ASP_CMD_SPDCHG]) begin
               nxt_s.tgt = s_ff.r_speed;
               nxt_s.spdchg = 1'b1;
               nxt_s.st = asp_pkg::ASP_ACCEL;
            end
            if (cause) begin
               // halt affects only this axis, never a partner axis
               nxt_s.c_halt = cmd[`ASP_CMD_HALT];
               nxt_s.speed = s_ff.speed;
               nxt_s.tleft = t_sel;
               nxt_s.st = asp_pkg::ASP_CALC;
            end
         end
         asp_pkg::ASP_CALC: begin
            // speed held while the slope is computed
            if (s_ff.tleft == '0) begin
               nxt_s.st = asp_pkg::ASP_FINISH;
            end else if (!s_ff.div_go && div_done) begin
               nxt_s.step = (div_quo == '0) ? SPD_W'(1) : div_quo;
               nxt_s.st = asp_pkg::ASP_DECEL;
               nxt_s.ms = MSW'(MS_CYC - 1);
            end
         end
         asp_pkg::ASP_DECEL: begin
            // halt commands are ignored while ramping down
            if (tick) begin
               nxt_s.speed = dec_spd;
               nxt_s.tleft = s_ff.tleft - 1'b1;
               if (s_ff.tleft == TIM_W'(1)) begin
                  nxt_s.st = asp_pkg::ASP_FINISH;
               end
            end
         end
         asp_pkg::ASP_FINISH: begin
            if (s_ff.speed == '0) begin
               nxt_s.speed = floor_spd;
            end
            if (wrap) begin
               nxt_s.st = asp_pkg::ASP_IDLE;
            end
         end
      endcase
      if (s_ff.st == asp_pkg::ASP_ACCEL || s_ff.st == asp_pkg::ASP_RUN) begin
         if (cause) begin
            nxt_s.div_go = 1'b1;
         end
      end
      if (hit) begin
         nxt_s.st = asp_pkg::ASP_IDLE;
      end
      if (moving && nxt_s.st == asp_pkg::ASP_IDLE) begin
         nxt_s.speed = '0;
         nxt_s.phase = '0;
         nxt_s.op = nxt_s.c_err  ? `ASP_OP_ERROR :
                    nxt_s.c_halt ? `ASP_OP_STOPPED :
                                   `ASP_OP_STANDBY;
      end
      if (hit_reg({rd.en, rd.addr, 36'h0}, `ASP_REG_ISTAT)) begin
         nxt_s.ist = 3'h0;
      end
      nxt_s.ist[`ASP_IRQ_DONE] = nxt_s.ist[`ASP_IRQ_DONE] ||
                                 (moving && nxt_s.st == asp_pkg::ASP_IDLE);
      nxt_s.ist[`ASP_IRQ_ERR] = nxt_s.ist[`ASP_IRQ_ERR] || err;
      nxt_s.ist[`ASP_IRQ_HIT] = nxt_s.ist[`ASP_IRQ_HIT] || hit;
      nxt_s.irq = |(nxt_s.ist & nxt_s.imask);
      nxt_s.pulse = (nxt_s.st != asp_pkg::ASP_IDLE) && nxt_s.phase[31];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
         s_ff.st <= asp_pkg::ASP_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   always_comb begin
      unique case (rd.addr)
         `ASP_REG_SPEED:  rd_data = 32'(s_ff.r_speed);
         `ASP_REG_BIAS:   rd_data = 32'(s_ff.r_bias);
         `ASP_REG_ACC:    rd_data = 32'(s_ff.r_acc);
         `ASP_REG_TARGET: rd_data = s_ff.target;
         `ASP_REG_TPOS:   rd_data = 32'(s_ff.r_tpos);
         `ASP_REG_TJOG:   rd_data = 32'(s_ff.r_tjog);
         `ASP_REG_THOME:  rd_data = 32'(s_ff.r_thome);
         `ASP_REG_TSPD:   rd_data = 32'(s_ff.r_tspd);
         `ASP_REG_STATUS: rd_data = {15'h0, s_ff.drv2, 2'h0,
                                     s_ff.st, s_ff.op};
         `ASP_REG_POS:    rd_data = s_ff.pos;
         `ASP_REG_ISTAT:  rd_data = {29'h0, s_ff.ist};
         `ASP_REG_IMASK:  rd_data = {29'h0, s_ff.imask};
         default:         rd_data = 32'h0;
      endcase
   end
   asp_axil u_axil (
      .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .wr(wr), .rd(rd),
      .rd_data(rd_data));
   asp_div #(.NW(SPD_W), .DW(TIM_W)) u_div (
      .clk(clk), .rst(rst), .go(s_ff.div_go), .num(div_num), .den(div_den),
      .done(div_done), .quo(div_quo));
   assign pulse_out = s_ff.pulse;
   assign dir_out   = s_ff.dir;
   assign irq       = s_ff.irq;
endmodule
